// [design/sync_two_flop.sv]
`timescale 1ns/10ps
`default_nettype none
module sync_two_flop #(
    parameter int WIDTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // lines idle high through the pull-ups
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;
endmodule
`default_nettype wire

// [design/two_wire_bus_mode_serial_port.sv]
// Contract
// - data line is open-drain out, sensed in
// - wake-up keeps data output released
// - address match after start sets flag
// - wake-up also flags on stop condition
// - transmitter samples real line into shifter
// - match status bit reads comparator result
// - shift out on falling edge, msb first
// - capture data line on rising edge
// - write starts only if enabled, clock idle
// - enable after write does not start
// - write during wait held until clocked
// - stop after eight bits, set flag
// - master clock low idle; level bit releases it
// - wait ends on release bit or write
// - slave send: write frees wait at once
// - slave receive fails if clock released
// - detect start and stop on data edges
// - stop sets stop flag, clears start flag
// - nine-clock wait flags on ninth rise
// - eight-clock wait flags on eighth rise
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module two_wire_bus_mode_serial_port #(
    parameter logic [7:0] HALF_CYC = 8'(two_wire_pkg::SCL_HALF_CYC)
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);
    if (HALF_CYC < 8'h02) begin : badHalf
        $error("HALF_CYC must be at least 2");
    end

    two_wire_pkg::xfer_state_t st_q, st_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [7:0] sr_q, sr_d, sva_q, sva_d, div_q, div_d;
    logic so_q, so_d, addrPhase_q, addrPhase_d, hit_q, hit_d;
    logic en_q, en_d, wake_q, wake_d, master_q, master_d, latch_q, latch_d;
    logic relEn_q, relEn_d, start_q, start_d, stop_q, stop_d;
    logic sel_q, sel_d, clc_q, clc_d, flag_q, flag_d, sclRel_q, sclRel_d;
    logic [1:0] wat_q, wat_d;
    logic sclPrev_q, sdaPrev_q, ack_q;
    logic [31:0] dat_q, dat_d;
    logic [1:0] lineSync;
    logic sclS, sdaS, sclRise, sclFall, startCond, stopCond, match;
    logic wbDo, wr, wrShift, wrTiming, startOk;
    logic [3:0] endCnt;
    logic [7:0] srNext;
    logic [7:0] byteNow;

    sync_two_flop #(.WIDTH(2)) lineSyncU (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn({sclIn, sdaIn}),
        .syncOut(lineSync)
    );

    assign sclS = lineSync[1];
    assign sdaS = lineSync[0];
    assign sclRise = sclS & ~sclPrev_q;
    assign sclFall = ~sclS & sclPrev_q;
    assign startCond = ~sdaS & sdaPrev_q & sclS & sclPrev_q;
    assign stopCond = sdaS & ~sdaPrev_q & sclS & sclPrev_q;
    assign match = (sr_q == sva_q);
    assign wbDo = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = wbDo & wb_we_i & wb_sel_i[0];
    assign wrShift = wr & (wb_adr_i == two_wire_pkg::ADR_SHIFT);
    assign wrTiming = wr & (wb_adr_i == two_wire_pkg::ADR_TIMING);
    // slave cannot start while the clock line already floats high
    assign startOk = en_q & (st_q != two_wire_pkg::ST_SHIFT)
        & (master_q | ~sclS);
    assign endCnt = wat_q[0] ? two_wire_pkg::BITS_WAIT9
        : two_wire_pkg::BITS_WAIT8;
    // the real line is taken in, so a sender can compare afterwards
    assign srNext = {sr_q[6:0], sdaS};
    // the ninth clock is not shifted, so the byte is the one held
    assign byteNow = (bitCnt_q < 4'h8) ? srNext : sr_q;

    always_comb begin
        st_d = st_q;
        bitCnt_d = bitCnt_q;
        sr_d = sr_q;
        sva_d = sva_q;
        div_d = div_q;
        so_d = so_q;
        addrPhase_d = addrPhase_q;
        hit_d = hit_q;
        en_d = en_q;
        wake_d = wake_q;
        master_d = master_q;
        latch_d = latch_q;
        relEn_d = relEn_q;
        start_d = start_q;
        stop_d = stop_q;
        sel_d = sel_q;
        clc_d = clc_q;
        flag_d = flag_q;
        sclRel_d = sclRel_q;
        wat_d = wat_q;
        dat_d = 32'h0000_0000;
        if (wbDo && !wb_we_i) begin
            unique case (wb_adr_i)
                two_wire_pkg::ADR_MODE: dat_d[7:0] = {en_q, match, wake_q,
                    3'h0, master_q, latch_q};
                two_wire_pkg::ADR_BUSCTL: dat_d[7:0] = {relEn_q, 3'h0,
                    start_q, stop_q, 2'h0};
                two_wire_pkg::ADR_SHIFT: dat_d[7:0] = sr_q;
                two_wire_pkg::ADR_SVA: dat_d[7:0] = sva_q;
                two_wire_pkg::ADR_TIMING: dat_d[7:0] = {1'b0, sel_q, sclS,
                    1'b0, clc_q, 1'b0, wat_q};
                two_wire_pkg::ADR_STATUS: dat_d[7:0] = {7'h00, flag_q};
                default: dat_d = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            unique case (wb_adr_i)
                two_wire_pkg::ADR_MODE: begin
                    en_d = wb_dat_i[two_wire_pkg::MODE_EN];
                    wake_d = wb_dat_i[two_wire_pkg::MODE_WAKE];
                    master_d = wb_dat_i[two_wire_pkg::MODE_MASTER];
                    latch_d = wb_dat_i[two_wire_pkg::MODE_LATCH];
                end
                two_wire_pkg::ADR_BUSCTL: begin
                    relEn_d = wb_dat_i[two_wire_pkg::BUS_RELEASE];
                end
                two_wire_pkg::ADR_SVA: begin
                    sva_d = wb_dat_i[7:0];
                end
                two_wire_pkg::ADR_TIMING: begin
                    sel_d = wb_dat_i[two_wire_pkg::TIM_SEL];
                    clc_d = wb_dat_i[two_wire_pkg::TIM_CLC];
                    wat_d = {wb_dat_i[two_wire_pkg::TIM_WATH],
                        wb_dat_i[two_wire_pkg::TIM_WATL]};
                end
                two_wire_pkg::ADR_STATUS: begin
                    if (wb_dat_i[two_wire_pkg::STAT_FLAG]) begin
                        flag_d = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (wrTiming && wb_dat_i[two_wire_pkg::TIM_WAIT_RELEASE]
            && st_q == two_wire_pkg::ST_WAIT) begin
            st_d = two_wire_pkg::ST_IDLE;
        end
        if (wrShift) begin
            // data is held even when no transfer can start yet
            sr_d = wb_dat_i[7:0];
            if (st_q == two_wire_pkg::ST_WAIT) begin
                st_d = two_wire_pkg::ST_IDLE;
            end
            if (startOk) begin
                st_d = two_wire_pkg::ST_SHIFT;
                bitCnt_d = 4'h0;
                so_d = wb_dat_i[7];
                div_d = HALF_CYC;
                sclRel_d = 1'b0;
            end
        end
        if (st_q == two_wire_pkg::ST_SHIFT) begin
            // master clock; a stretching slave stalls the high phase
            if (master_q && !clc_q) begin
                if (div_q != 8'h00) begin
                    div_d = div_q - 8'h01;
                end else if (!sclRel_q) begin
                    sclRel_d = 1'b1;
                    div_d = HALF_CYC;
                end else if (sclS) begin
                    sclRel_d = 1'b0;
                    div_d = HALF_CYC;
                end
            end
            if (sclRise) begin
                bitCnt_d = bitCnt_q + 4'h1;
                if (bitCnt_q < 4'h8) begin
                    sr_d = srNext;
                end
                if (bitCnt_q + 4'h1 == endCnt) begin
                    addrPhase_d = 1'b0;
                    hit_d = ~wake_q | (addrPhase_q && byteNow == sva_q);
                    if (!wake_q || (addrPhase_q && byteNow == sva_q)) begin
                        flag_d = 1'b1;
                    end
                end
            end
            if (sclFall) begin
                if (bitCnt_q == endCnt) begin
                    // hold the clock low as a wait once the byte is done if hit_q, else return to idle
                    st_d = hit_q ? two_wire_pkg::ST_WAIT
                        : two_wire_pkg::ST_IDLE;
                    so_d = 1'b1;
                end else begin
                    so_d = (bitCnt_q < 4'h8) ? sr_q[7] : 1'b1;
                end
            end
        end
        if (startCond) begin
            start_d = 1'b1;
            stop_d = 1'b0;
            addrPhase_d = 1'b1;
            if (en_q && wake_q && !master_q) begin
                // wake-up receives the address with no shifter write
                st_d = two_wire_pkg::ST_SHIFT;
                bitCnt_d = 4'h0;
                so_d = 1'b1;
            end
        end
        if (stopCond) begin
            stop_d = 1'b1;
            start_d = 1'b0;
            if (en_q && wake_q) begin
                flag_d = 1'b1;
            end
            if (!master_q) begin
                st_d = two_wire_pkg::ST_IDLE;
            end
            if (relEn_q) begin
                so_d = 1'b1;
            end
        end
        if (!en_q) begin
            st_d = two_wire_pkg::ST_IDLE;
            so_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= two_wire_pkg::ST_IDLE;
            bitCnt_q <= 4'h0;
            sr_q <= two_wire_pkg::SHIFT_RST;
            sva_q <= two_wire_pkg::SVA_RST;
            div_q <= 8'h00;
            so_q <= 1'b1;
            addrPhase_q <= 1'b0;
            hit_q <= 1'b0;
            {en_q, wake_q} <= 2'h0;
            master_q <= two_wire_pkg::MODE_RST[two_wire_pkg::MODE_MASTER];
            latch_q <= two_wire_pkg::MODE_RST[two_wire_pkg::MODE_LATCH];
            relEn_q <= two_wire_pkg::BUSCTL_RST[two_wire_pkg::BUS_RELEASE];
            {start_q, stop_q} <= 2'h0;
            sel_q <= two_wire_pkg::TIM_RST[two_wire_pkg::TIM_SEL];
            clc_q <= two_wire_pkg::TIM_RST[two_wire_pkg::TIM_CLC];
            wat_q <= two_wire_pkg::TIM_RST[1:0];
            flag_q <= 1'b0;
            sclRel_q <= 1'b0;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            bitCnt_q <= bitCnt_d;
            sr_q <= sr_d;
            sva_q <= sva_d;
            div_q <= div_d;
            so_q <= so_d;
            addrPhase_q <= addrPhase_d;
            hit_q <= hit_d;
            {en_q, wake_q} <= {en_d, wake_d};
            master_q <= master_d;
            latch_q <= latch_d;
            relEn_q <= relEn_d;
            {start_q, stop_q} <= {start_d, stop_d};
            sel_q <= sel_d;
            clc_q <= clc_d;
            wat_q <= wat_d;
            flag_q <= flag_d;
            sclRel_q <= sclRel_d;
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
            ack_q <= wbDo;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    // both lines only ever pull low; the pull-ups make the high level
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = en_q & ((st_q == two_wire_pkg::ST_WAIT) | ~latch_q
        | (master_q & ~clc_q
        & ~((st_q == two_wire_pkg::ST_SHIFT) & sclRel_q)));
    assign sdaOe = en_q & ~wake_q & ~so_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence lastRise;
        st_q == two_wire_pkg::ST_SHIFT && sclRise && en_q
            && !startCond && !stopCond && bitCnt_q + 4'h1 == endCnt;
    endsequence
    sequence addrHit;
        lastRise ##0 (wake_q && addrPhase_q && byteNow == sva_q);
    endsequence

    chk_data_opendrain: assert property (sdaOut == 1'b0
        && (sdaOe -> !so_q))
        else $error("data line driven high or out of turn");
    chk_wake_released: assert property (wake_q |-> !sdaOe)
        else $error("data line pulled while wake-up set");
    chk_addr_flag: assert property (addrHit |=> flag_q)
        else $error("address match did not raise flag");
    chk_wake_stop: assert property (stopCond && wake_q && en_q
        |=> flag_q)
        else $error("stop in wake-up did not raise flag");
    chk_match_read: assert property (wbDo && !wb_we_i
        && wb_adr_i == two_wire_pkg::ADR_MODE
        |=> wb_ack_o && wb_dat_o[6] == $past(match))
        else $error("match status read wrong");
    chk_rise_capture: assert property (st_q == two_wire_pkg::ST_SHIFT
        && sclRise && bitCnt_q < 4'h8 && !wrShift
        |=> sr_q[0] == $past(sdaS))
        else $error("line not captured on rising clock");
    chk_fall_shift: assert property (st_q == two_wire_pkg::ST_SHIFT
        && sclFall && bitCnt_q < 4'h8 && bitCnt_q != endCnt
        && !stopCond && !startCond && en_q
        |=> so_q == $past(sr_q[7]))
        else $error("next bit not shifted out on falling clock");
    chk_start_gate: assert property (wrShift && !en_q
        |=> st_q != two_wire_pkg::ST_SHIFT)
        else $error("transfer started while disabled");
    chk_slave_blocked: assert property (wrShift && !master_q && sclS
        && st_q == two_wire_pkg::ST_IDLE && !startCond
        |=> st_q == two_wire_pkg::ST_IDLE)
        else $error("slave started with clock released");
    chk_end_flag: assert property (lastRise ##0 !wake_q
        |=> flag_q ##0 bitCnt_q == endCnt)
        else $error("byte end did not raise flag");
    chk_wait_hold: assert property (st_q == two_wire_pkg::ST_WAIT && en_q
        |-> sclOe)
        else $error("clock not held low in wait");
    chk_clc_release: assert property (master_q && clc_q && latch_q
        && st_q != two_wire_pkg::ST_WAIT |-> !sclOe)
        else $error("clock not released by level control");
    chk_stop_flags: assert property (stopCond |=> stop_q && !start_q)
        else $error("stop flags wrong");
    chk_start_flag: assert property (startCond |=> start_q)
        else $error("start not detected");
    chk_wait_leave: assert property (st_q == two_wire_pkg::ST_WAIT
        && wrTiming && wb_dat_i[two_wire_pkg::TIM_WAIT_RELEASE] && !wrShift
        |=> st_q == two_wire_pkg::ST_IDLE)
        else $error("wait not released");
endmodule
`default_nettype wire

// [design/two_wire_pkg.sv]
`default_nettype none
package two_wire_pkg;
    // register byte addresses, one aligned 32-bit word each
    localparam logic [4:0] ADR_MODE = 5'h00;
    localparam logic [4:0] ADR_BUSCTL = 5'h04;
    localparam logic [4:0] ADR_SHIFT = 5'h08;
    localparam logic [4:0] ADR_SVA = 5'h0c;
    localparam logic [4:0] ADR_TIMING = 5'h10;
    localparam logic [4:0] ADR_STATUS = 5'h14;
    // mode_register_zero fields
    localparam int MODE_EN = 7;
    localparam int MODE_MATCH = 6;
    localparam int MODE_WAKE = 5;
    localparam int MODE_MASTER = 1;
    localparam int MODE_LATCH = 0;
    // bus_control_register fields
    localparam int BUS_RELEASE = 7;
    localparam int BUS_START = 3;
    localparam int BUS_STOP = 2;
    // interrupt_timing_register fields
    localparam int TIM_SEL = 6;
    localparam int TIM_CLD = 5;
    localparam int TIM_CLC = 3;
    localparam int TIM_WAIT_RELEASE = 2;
    localparam int TIM_WATH = 1;
    localparam int TIM_WATL = 0;
    // status register field
    localparam int STAT_FLAG = 0;
    // reset values
    localparam logic [7:0] MODE_RST = 8'h01;
    localparam logic [7:0] BUSCTL_RST = 8'h00;
    localparam logic [7:0] TIM_RST = 8'h03;
    localparam logic [7:0] SHIFT_RST = 8'hff;
    localparam logic [7:0] SVA_RST = 8'h00;
    // timing
    localparam int CLK_NS = 100;
    localparam int SCL_HALF_NS = 5000;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] BITS_WAIT8 = 4'h8;
    localparam logic [3:0] BITS_WAIT9 = 4'h9;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_WAIT = 2'b10
    } xfer_state_t;
endpackage
`default_nettype wire

// [dv/two_wire_bus_mode_serial_port_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module two_wire_bus_mode_serial_port_tb;
    logic clk, rstN, cyc, stb, we, ack, sclO, sdaO;
    logic sclOe, sdaOe, pSclOe, pSdaOe, sclLine, sdaLine;
    logic [4:0] adr;
    logic [31:0] datI, datO;
    logic [3:0] sel;
    int errTotal = 0;
    int nChecks = 0;
    // open-drain lines with pull-ups
    assign sclLine = !(sclOe || pSclOe);
    assign sdaLine = !(sdaOe || pSdaOe);
    two_wire_bus_mode_serial_port #(.HALF_CYC(8'h04)) dut (
        .ref_clk(clk), .rst_n(rstN), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(datI), .wb_sel_i(sel),
        .wb_dat_o(datO), .wb_ack_o(ack), .sclIn(sclLine), .sclOut(sclO),
        .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaO), .sdaOe(sdaOe)
    );
    two_wire_peer peer (
        .sclLine(sclLine), .sdaLine(sdaLine), .sclOe(pSclOe), .sdaOe(pSdaOe)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic stopTest();
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [4:0] a,
                      input logic [7:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datI <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            errTotal++;
            $display("[FAIL] %0t bus answer missing", $time);
            stopTest();
        end
        r = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] r;
        wb(1'b0, a, 8'h00, r);
        chk(r, {24'h000000, e});
    endtask
    task automatic t_reset();
        logic [7:0] tab [7];
        tab = '{two_wire_pkg::MODE_RST, two_wire_pkg::BUSCTL_RST,
                two_wire_pkg::SHIFT_RST, two_wire_pkg::SVA_RST,
                two_wire_pkg::TIM_RST | 8'h20, 8'h00, 8'h00};
        wr(5'h18, 8'hff);
        for (int i = 0; i < 7; i++) rd(5'(i * 4), tab[i]);
        chk(sclO, 1'b0);
        chk(sdaO, 1'b0);
        $display("reset values done");
    endtask
    task automatic t_master();
        wr(5'h00, 8'h03);
        wr(5'h08, 8'h5a);
        wr(5'h00, 8'h83);
        repeat (100) @(posedge clk);
        rd(5'h14, 8'h00);
        chk(sclOe, 1'b1);
        wr(5'h10, 8'h0b);
        chk(sclOe, 1'b0);
        repeat (5) @(posedge clk);
        rd(5'h10, 8'h2b);
        peer.hold_scl(1'b1);
        repeat (5) @(posedge clk);
        rd(5'h10, 8'h0b);
        peer.hold_scl(1'b0);
        wr(5'h08, 8'h5a);
        repeat (100) @(posedge clk);
        chk(sclOe, 1'b0);
        rd(5'h14, 8'h00);
        wr(5'h00, 8'h01);
        wr(5'h10, 8'h03);
        $display("master clock control done");
    endtask
    task automatic t_slave();
        logic [7:0] rx;
        wr(5'h0c, 8'ha5);
        wr(5'h00, 8'h81);
        wr(5'h04, 8'h80);
        peer.start_c();
        rd(5'h04, 8'h88);
        wr(5'h00, 8'h80);
        wr(5'h08, 8'hff);
        wr(5'h00, 8'h81);
        peer.xfer(8'ha5, 8'h00, rx, 9);
        rd(5'h08, 8'ha5);
        rd(5'h14, 8'h01);
        rd(5'h00, 8'hc1);
        chk(sclOe, 1'b1);
        wr(5'h14, 8'h01);
        rd(5'h14, 8'h00);
        wr(5'h0c, 8'hc3);
        wr(5'h00, 8'h80);
        wr(5'h08, 8'hc3);
        wr(5'h00, 8'h81);
        peer.xfer(8'hff, 8'h01, rx, 9);
        chk(rx, 8'hc2);
        rd(5'h08, 8'hc2);
        rd(5'h00, 8'h81);
        rd(5'h14, 8'h01);
        wr(5'h10, 8'h07);
        chk(sclOe, 1'b0);
        peer.stop_c();
        rd(5'h04, 8'h84);
        $display("slave receive and send done");
    endtask
    task automatic t_wait8();
        logic [7:0] rx;
        wr(5'h14, 8'h01);
        wr(5'h08, 8'hff);
        wr(5'h10, 8'h02);
        peer.hold_scl(1'b1);
        wr(5'h00, 8'h80);
        wr(5'h08, 8'hff);
        wr(5'h00, 8'h81);
        peer.xfer(8'h3c, 8'h00, rx, 8);
        rd(5'h08, 8'h3c);
        rd(5'h14, 8'h01);
        chk(sclOe, 1'b1);
        wr(5'h10, 8'h07);
        chk(sclOe, 1'b0);
        wr(5'h14, 8'h01);
        $display("eight-clock wait done");
    endtask
    task automatic t_wake();
        logic [7:0] rx;
        wr(5'h14, 8'h01);
        wr(5'h0c, 8'ha5);
        wr(5'h10, 8'h43);
        wr(5'h00, 8'ha1);
        peer.start_c();
        peer.xfer(8'ha5, 8'h00, rx, 9);
        chk(sdaOe, 1'b0);
        rd(5'h14, 8'h01);
        wr(5'h10, 8'h47);
        wr(5'h14, 8'h01);
        rd(5'h14, 8'h00);
        peer.stop_c();
        rd(5'h14, 8'h01);
        chk(peer.stretchErr, 0);
        $display("wake-up done");
    endtask
    initial begin
        rstN = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 5'h00;
        datI = 32'h00000000;
        sel = 4'h1;
        repeat (2) @(posedge clk);
        rstN <= 1'b1;
        t_reset();
        t_master();
        t_slave();
        t_wait8();
        t_wake();
        stopTest();
    end
endmodule
`default_nettype wire

// [dv/two_wire_peer.sv]
`timescale 1ns/10ps
`default_nettype none
module two_wire_peer #(
    parameter int HALF_NS = 400
) (
    input wire logic sclLine,
    input wire logic sdaLine,
    output logic sclOe,
    output logic sdaOe
);
    int stretchErr = 0;
    initial begin
        sclOe = 1'b0;
        sdaOe = 1'b0;
    end
    task automatic hold_scl(input logic v);
        #10 sclOe = v;
    endtask
    // a slave may stretch the clock, so never assume the line rose
    task automatic wait_high();
        int n;
        n = 0;
        while (!sclLine && n < 400) begin
            #100;
            n++;
        end
        if (!sclLine) stretchErr++;
    endtask
    // data falls while clock high
    task automatic start_c();
        // keep line changes off the sampling clock edge
        #10;
        sdaOe = 1'b0;
        sclOe = 1'b0;
        wait_high();
        #HALF_NS sdaOe = 1'b1;
        #HALF_NS sclOe = 1'b1;
        #HALF_NS;
    endtask
    // data rises while clock high
    task automatic stop_c();
        #10;
        sclOe = 1'b1;
        sdaOe = 1'b1;
        #HALF_NS sclOe = 1'b0;
        wait_high();
        #HALF_NS sdaOe = 1'b0;
        #HALF_NS;
    endtask
    // eight data clocks, a released acknowledge clock when nClk is 9; pull
    // forces zeros to fake a collision; clock is left held low
    task automatic xfer(input logic [7:0] tx, input logic [7:0] pull,
                        output logic [7:0] rx, input int nClk);
        #10;
        for (int i = 0; i < nClk; i++) begin
            sdaOe = (i < 8) ? (!tx[7-i] || pull[7-i]) : 1'b0;
            #HALF_NS sclOe = 1'b0;
            wait_high();
            #HALF_NS;
            if (i < 8) rx[7-i] = sdaLine;
            sclOe = 1'b1;
        end
        #HALF_NS sdaOe = 1'b0;
    endtask
endmodule
`default_nettype wire
